// File: design/fracmul_pkg.sv
// Shared constants and types for the fractional multiply datapath
package fracmul_pkg;
	localparam logic [5:0] MAJOR_EXT = 6'h1F;
	localparam logic [4:0] SUB_RND_WORD = 5'h17;
	localparam logic [4:0] SUB_TRN_HALF = 5'h1E;
	localparam logic [4:0] SUB_RND_HALF = 5'h1F;
	localparam logic [5:0] FUNC_MUL_GRP = 6'h18;
	localparam logic [5:0] FUNC_ADD_GRP = 6'h10;
	localparam int OUFLAG_BIT = 21;
	localparam logic [31:0] HALF_RND_ADD = 32'h0000_8000;
	localparam logic [31:0] HALF_SAT = 32'h7FFF_0000;
	localparam logic [15:0] HALF_MIN = 16'h8000;
	localparam logic [31:0] WORD_MIN = 32'h8000_0000;
	localparam logic [63:0] WORD_RND_ADD = 64'h0000_0000_8000_0000;
	localparam logic [63:0] WORD_SAT = 64'h7FFF_FFFF_0000_0000;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

	typedef enum {OP_NONE, OP_RND_HALF, OP_RND_WORD, OP_TRN_HALF} op_t;

	typedef struct packed {
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] dest;
	} reg_sel_t;

	typedef struct packed {
		logic valid;
		logic [4:0] dest;
		logic [63:0] data;
	} wb_t;
endpackage

// File: design/fracmul_unit.sv
// Fractional multiply datapath: decode, compute, write back, status
`timescale 1ns/10ps
module fracmul_unit
	import fracmul_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_issue,
	input wire logic [31:0] i_instr,
	input wire logic i_ext_enable,
	input wire logic [63:0] i_src_a,
	input wire logic [63:0] i_src_b,
	output reg_sel_t o_reg_sel,
	output logic o_claimed,
	output wb_t o_wb,
	output logic o_ext_disabled,
	output logic o_acc_base_clobber,
	output logic [31:0] o_status
);
	op_t op;
	logic [15:0] lane_hi;
	logic [15:0] lane_lo;
	logic sat_hi;
	logic sat_lo;
	logic sat_word;
	logic [31:0] word_res;
	logic [63:0] next_data;
	logic next_ovf;

	always_comb begin
		op = OP_NONE;
		if (i_instr[31:26] == MAJOR_EXT) begin
			if (i_instr[10:6] == SUB_RND_WORD &&
			    i_instr[5:0] == FUNC_MUL_GRP)
				op = OP_RND_WORD;
			else if (i_instr[10:6] == SUB_TRN_HALF &&
			         i_instr[5:0] == FUNC_ADD_GRP)
				op = OP_TRN_HALF;
			else if (i_instr[10:6] == SUB_RND_HALF &&
			         i_instr[5:0] == FUNC_ADD_GRP)
				op = OP_RND_HALF;
		end
	end

	assign o_reg_sel = '{src_a: i_instr[25:21], src_b: i_instr[20:16],
		dest: i_instr[15:11]};
	assign o_claimed = i_issue && op != OP_NONE;

	function automatic logic [15:0] half_mul(input logic [15:0] a,
		input logic [15:0] b, input logic rnd);
		logic signed [31:0] p;
		logic [31:0] t;
		p = $signed(a) * $signed(b);
		t = {p[30:0], 1'b0};
		if (a == HALF_MIN && b == HALF_MIN)
			t = HALF_SAT;
		else if (rnd)
			t = t + HALF_RND_ADD;
		return t[31:16];
	endfunction

	function automatic logic [31:0] word_mul(input logic [31:0] a,
		input logic [31:0] b);
		logic signed [63:0] p;
		logic [63:0] t;
		p = $signed(a) * $signed(b);
		t = {p[62:0], 1'b0};
		if (a == WORD_MIN && b == WORD_MIN)
			t = WORD_SAT;
		else
			t = t + WORD_RND_ADD;
		return t[63:32];
	endfunction

	always_comb begin
		lane_hi = half_mul(i_src_a[31:16], i_src_b[31:16], op == OP_RND_HALF);
		lane_lo = half_mul(i_src_a[15:0], i_src_b[15:0], op == OP_RND_HALF);
		sat_hi = i_src_a[31:16] == HALF_MIN && i_src_b[31:16] == HALF_MIN;
		sat_lo = i_src_a[15:0] == HALF_MIN && i_src_b[15:0] == HALF_MIN;
		sat_word = i_src_a[31:0] == WORD_MIN && i_src_b[31:0] == WORD_MIN;
		word_res = word_mul(i_src_a[31:0], i_src_b[31:0]);
		if (op == OP_RND_WORD) begin
			next_data = {{32{word_res[31]}}, word_res};
			next_ovf = sat_word;
		end else begin
			next_data = {{32{lane_hi[15]}}, lane_hi, lane_lo};
			next_ovf = sat_hi || sat_lo;
		end
	end

	// Disabled extension never writes back; only that fault is raised
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wb <= '0;
		end else begin
			o_wb.valid <= o_claimed && i_ext_enable;
			o_wb.dest <= i_instr[15:11];
			o_wb.data <= next_data;
		end
	end

	// Operand values never cause a fault
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_ext_disabled <= 1'b0;
		else
			o_ext_disabled <= o_claimed && !i_ext_enable;
	end

	// Signals the pipeline that the base pair may now hold garbage
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_acc_base_clobber <= 1'b0;
		else
			o_acc_base_clobber <= o_claimed && i_ext_enable;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_status <= STATUS_RESET;
		else if (o_claimed && i_ext_enable && next_ovf)
			o_status[OUFLAG_BIT] <= 1'b1;
	end

	// Reference results built from the raw products, not from the
	// shifted intermediate, so a shared slip cannot hide itself
	logic signed [31:0] chk_prod_lo;
	logic signed [63:0] chk_prod_w;
	logic [15:0] chk_rnd_lo;
	logic [31:0] chk_rnd_w;
	assign chk_prod_lo = $signed(i_src_a[15:0]) * $signed(i_src_b[15:0]);
	assign chk_prod_w = $signed(i_src_a[31:0]) * $signed(i_src_b[31:0]);
	assign chk_rnd_lo = chk_prod_lo[30:15] + {15'h0, chk_prod_lo[14]};
	assign chk_rnd_w = chk_prod_w[62:31] + {31'h0, chk_prod_w[30]};

	sticky_ovf_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		$past(o_status[OUFLAG_BIT]) |-> o_status[OUFLAG_BIT])
		else $error("overflow flag cleared");
	others_zero_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_status[20:0] == '0 && o_status[31:22] == '0)
		else $error("other status bits changed");
	word_sat_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_RND_WORD && sat_word |=>
		o_wb.data == 64'h0000_0000_7FFF_FFFF && o_status[OUFLAG_BIT])
		else $error("word saturation wrong");
	word_flag_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_RND_WORD && sat_word |=>
		o_status[OUFLAG_BIT])
		else $error("word overflow flag not set");
	word_rnd_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_RND_WORD && !sat_word |=>
		o_wb.data[31:0] == $past(chk_rnd_w))
		else $error("word rounding wrong");
	half_sat_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_TRN_HALF && sat_lo |=>
		o_wb.data[15:0] == 16'h7FFF && o_status[OUFLAG_BIT])
		else $error("halfword saturation wrong");
	trn_flag_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_TRN_HALF &&
		(sat_hi || sat_lo) |=> o_status[OUFLAG_BIT])
		else $error("truncating overflow flag not set");
	trn_lo_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_TRN_HALF && !sat_lo |=>
		o_wb.data[15:0] == $past(chk_prod_lo[30:15]))
		else $error("truncating lane wrong");
	rnd_lo_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_RND_HALF && !sat_lo |=>
		o_wb.data[15:0] == $past(chk_rnd_lo))
		else $error("rounded lane wrong");
	rnd_sat_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && op == OP_RND_HALF && sat_hi |=>
		o_wb.data[31:16] == 16'h7FFF && o_status[OUFLAG_BIT])
		else $error("rounded lane saturation wrong");
	sign_ext_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_wb.valid |-> o_wb.data[63:32] == {32{o_wb.data[31]}})
		else $error("sign extension wrong");
	clob_pair_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_acc_base_clobber == o_wb.valid)
		else $error("accumulator clobber not paired with write back");
	fault_excl_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		!(o_wb.valid && o_ext_disabled))
		else $error("write back while disabled");
	claim_answer_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed |=> o_wb.valid || o_ext_disabled)
		else $error("claimed operation got no answer");
	idle_quiet_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		!o_claimed |=> !o_wb.valid && !o_ext_disabled)
		else $error("output without a claimed operation");
	dis_quiet_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && !i_ext_enable |=> $stable(o_status))
		else $error("status changed while disabled");
	decode_word_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		i_issue && i_ext_enable && i_instr[31:26] == 6'h1F &&
		i_instr[10:0] == {5'h17, 6'h18} |=> o_wb.valid)
		else $error("word variant not decoded");
	wb_dest_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable |=> o_wb.dest == $past(i_instr[15:11]))
		else $error("write back destination wrong");
	decode_trn_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		i_issue && i_instr[31:26] == 6'h1F &&
		i_instr[10:0] == {5'h1E, 6'h10} |-> o_claimed && op == OP_TRN_HALF)
		else $error("truncating variant not decoded");
	decode_rnd_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		i_issue && i_instr[31:26] == 6'h1F &&
		i_instr[10:0] == {5'h1F, 6'h10} |-> o_claimed && op == OP_RND_HALF)
		else $error("rounded variant not decoded");
	no_ovf_a: assert property (
		@(posedge i_clk) disable iff (!i_reset_n)
		o_claimed && i_ext_enable && !next_ovf && !o_status[OUFLAG_BIT] |=>
		!o_status[OUFLAG_BIT])
		else $error("spurious overflow");

	word_cov: cover property (@(posedge i_clk) o_claimed && op == OP_RND_WORD);
	rnd_cov: cover property (@(posedge i_clk) o_claimed && op == OP_RND_HALF
		&& sat_hi);
	trn_cov: cover property (@(posedge i_clk) o_claimed && op == OP_TRN_HALF);
	trn_sat_cov: cover property (@(posedge i_clk) o_claimed &&
		op == OP_TRN_HALF && sat_lo);
	dis_cov: cover property (@(posedge i_clk) o_ext_disabled);
endmodule

// File: sim/gpr_model.sv
// Register file standing in for the core pipeline around the unit
`timescale 1ns/10ps
module gpr_model
	import fracmul_pkg::*;
(
	input wire logic i_clk,
	input wire reg_sel_t i_sel,
	input wire wb_t i_wb,
	input wire logic i_acc_clobber,
	output logic [63:0] o_a,
	output logic [63:0] o_b
);
	logic [63:0] regs [32];
	initial foreach (regs[i]) regs[i] = 64'h0;
	assign o_a = regs[i_sel.src_a];
	assign o_b = regs[i_sel.src_b];
	// Plain always so the bench may preload operands
	always @(posedge i_clk) begin
		if (i_wb.valid) regs[i_wb.dest] <= i_wb.data;
	end
	// Software's saved copy of the base pair; value is arbitrary
	localparam logic [63:0] ACC_COPY = 64'h0123_4567_89AB_CDEF;
	logic [63:0] acc_base = ACC_COPY;
	logic acc_dirty = 1'b0;
	// A multiply trashes the pair, then software restores its copy
	always @(posedge i_clk) begin
		acc_dirty <= i_acc_clobber;
		if (i_acc_clobber)
			acc_base <= ~ACC_COPY;
		else if (acc_dirty)
			acc_base <= ACC_COPY;
	end
endmodule

// File: sim/fracmul_unit_tb.sv
// Self-checking bench for the fractional multiply unit
`timescale 1ns/10ps
module fracmul_unit_tb;
	import fracmul_pkg::*;
	logic i_clk = 0, i_reset_n = 0, i_issue = 0, i_ext_enable = 0;
	logic [31:0] i_instr = 32'h0;
	logic [63:0] src_a, src_b;
	reg_sel_t sel;
	wb_t wb;
	logic claimed, ext_dis, clob, sticky = 0;
	logic [31:0] status;
	int n_errors = 0, samples_checked = 0;
	fracmul_unit dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_issue(i_issue), .i_instr(i_instr), .i_ext_enable(i_ext_enable),
		.i_src_a(src_a), .i_src_b(src_b), .o_reg_sel(sel),
		.o_claimed(claimed), .o_wb(wb), .o_ext_disabled(ext_dis),
		.o_acc_base_clobber(clob), .o_status(status));
	gpr_model gpr_u (.i_clk(i_clk), .i_sel(sel), .i_wb(wb),
		.i_acc_clobber(clob), .o_a(src_a), .o_b(src_b));
	initial forever #50 i_clk = ~i_clk;
	task automatic check(logic [63:0] seen, logic [63:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	function automatic logic [15:0] lane(logic [15:0] a, b, logic rnd);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		p = (p <<< 1) + (rnd ? 32'sh8000 : 32'sh0);
		return (a == HALF_MIN && b == HALF_MIN) ? 16'h7FFF : p[31:16];
	endfunction
	function automatic logic [63:0] wres(logic [31:0] a, b);
		logic signed [63:0] p;
		p = $signed(a) * $signed(b);
		p = (p <<< 1) + 64'sh8000_0000;
		if (a == WORD_MIN && b == WORD_MIN) p = WORD_SAT;
		return {{32{p[63]}}, p[63:32]};
	endfunction
	// Operands sit in r3 and r7, result goes to r9
	task automatic op(logic [4:0] sub, logic [5:0] fn, logic [63:0] a, b,
		logic en);
		logic [15:0] l, r;
		logic w;
		w = sub == SUB_RND_WORD;
		l = lane(a[31:16], b[31:16], sub == SUB_RND_HALF);
		r = lane(a[15:0], b[15:0], sub == SUB_RND_HALF);
		@(negedge i_clk);
		gpr_u.regs[3] = a;
		gpr_u.regs[7] = b;
		i_instr = {MAJOR_EXT, 5'h03, 5'h07, 5'h09, sub, fn};
		i_issue = 1;
		i_ext_enable = en;
		#1 check(sel, {5'h03, 5'h07, 5'h09});
		check(claimed, 1);
		@(negedge i_clk);
		i_issue = 0;
		sticky |= en & (w ? a[31:0] == WORD_MIN && b[31:0] == WORD_MIN
			: (a[31:16] == HALF_MIN && b[31:16] == HALF_MIN) ||
			(a[15:0] == HALF_MIN && b[15:0] == HALF_MIN));
		check(wb.valid, en);
		check(ext_dis, !en);
		check(clob, en);
		check(status, {10'h0, sticky, 21'h0});
		if (en) check(wb.dest, 5'h09);
		if (en) check(wb.data, w ? wres(a[31:0], b[31:0])
			: {{32{l[15]}}, l, r});
	endtask
	task automatic unknown_test();
		@(negedge i_clk);
		i_instr = {MAJOR_EXT, 5'h03, 5'h07, 5'h09, 5'h00, FUNC_ADD_GRP};
		i_issue = 1;
		i_ext_enable = 1;
		#1 check(claimed, 0);
		@(negedge i_clk);
		i_issue = 0;
		check({wb.valid, ext_dis}, 0);
	endtask
	// Mid-run reset clears the sticky flag so each variant sets it afresh
	task automatic reset_pulse();
		@(negedge i_clk);
		i_reset_n = 0;
		repeat (2) @(negedge i_clk);
		i_reset_n = 1;
		sticky = 0;
		check(status, 0);
		check({wb.valid, ext_dis, clob}, 0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge i_clk);
		i_reset_n = 1;
		check(status, 0);
		op(SUB_TRN_HALF, FUNC_ADD_GRP, 64'h1_7FFF_8001, 64'h7FFF_8000, 1);
		op(SUB_RND_HALF, FUNC_ADD_GRP, 64'hF_4001_C000, 64'h2_C000_0001,
			1);
		op(SUB_RND_WORD, FUNC_MUL_GRP, 64'hFF_C000_0001, 64'h4000_0001,
			1);
		op(SUB_RND_WORD, FUNC_MUL_GRP, 64'h8000_0000, 64'h8000_0000, 0);
		unknown_test();
		op(SUB_RND_HALF, FUNC_ADD_GRP, 64'h8000_8000, 64'h8000_8000,
			1);
		reset_pulse();
		op(SUB_TRN_HALF, FUNC_ADD_GRP, 64'h1234_8000, 64'h5678_8000,
			1);
		reset_pulse();
		op(SUB_RND_WORD, FUNC_MUL_GRP, 64'h8000_0000, 64'h8000_0000,
			1);
		repeat (2) @(negedge i_clk);
		check(gpr_u.acc_base, 64'h0123_4567_89AB_CDEF);
		report_and_stop();
	end
endmodule
